// File: include/psc_pkg.sv
package psc_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int PSC_PORTS = 2;
  localparam int PSC_OUTS  = 4;
  localparam int PSC_INS   = 6;
  localparam int PSC_GRP   = 3;
  localparam int PSC_AW    = 8;
  localparam int PSC_DW    = 16;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] PSC_PORT_STRIDE    = 8'h08;
  localparam logic [2:0] PSC_OFF_OUTEN      = 3'h0;
  localparam logic [2:0] PSC_OFF_OUTVAL     = 3'h1;
  localparam logic [2:0] PSC_OFF_INSTAT     = 3'h2;
  localparam logic [2:0] PSC_OFF_INTMASK    = 3'h3;
  localparam logic [2:0] PSC_OFF_INTMODE    = 3'h4;
  localparam logic [2:0] PSC_OFF_INTFLAG    = 3'h5;
  localparam logic [7:0] PSC_ADDR_ALL_OUTEN  = 8'h40;
  localparam logic [7:0] PSC_ADDR_ALL_OUTVAL = 8'h41;
  localparam logic [7:0] PSC_ADDR_SYS_OUTEN  = 8'h60;
  localparam logic [7:0] PSC_ADDR_SYS_OUTVAL = 8'h61;

  // ************************************************************
  // Fields
  // ************************************************************
  localparam int PSC_MODE_RISE = 0;
  localparam int PSC_MODE_FALL = 1;
  localparam int PSC_MODE_GRP0 = 2;
  localparam int PSC_MODE_EN   = 7;
  localparam int PSC_FLAG_FALL = 8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] PSC_OUTEN_RST  = 4'h0;
  localparam logic [3:0] PSC_OUTVAL_RST = 4'h5;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [PSC_AW-1:0] addr;
    logic [PSC_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } psc_bus_s;

  typedef struct packed {
    logic [PSC_OUTS-1:0] value;
    logic [PSC_OUTS-1:0] oeN;
  } psc_out_s;

endpackage

// File: verilog/psc_sideband.sv
`timescale 1ns/1ns
// Function
// - Four outputs per port; port, device, system writes
// - Per-port enables; all outputs disabled after reset
// - Value register; A outputs one, B zero
// - Six inputs per port readable as status
// - Interrupt on falling, rising or both edges
// - One flag register records input and edge
// - Interrupt active low, only ever pulls low
// - Shared wired-OR line, low means any device
// - Source is one input or group OR
module psc_sideband
  import psc_pkg::*;
#(
  parameter int PORTS = PSC_PORTS
)(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  // Register port
  input  wire psc_bus_s                     busReq,
  output logic     [PSC_DW-1:0]             rdata,
  // Module-side pins
  input  wire logic [PORTS-1:0][PSC_INS-1:0] inPins,
  output psc_out_s [PORTS-1:0]              outPins,
  // Host interrupt, open drain
  output logic                              hostIntOut,
  output logic                              hostIntOeN
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  // Port windows must stay below the device-wide addresses
  if (PORTS < 1 || PORTS > 8)
  begin : g_bad_ports
    $error("psc_sideband: PORTS must be 1 to 8");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [PORTS-1:0][PSC_OUTS-1:0] outEn;
    logic [PORTS-1:0][PSC_OUTS-1:0] outVal;
    logic [PORTS-1:0][PSC_INS-1:0]  sync1;
    logic [PORTS-1:0][PSC_INS-1:0]  sync2;
    logic [PORTS-1:0][PSC_INS-1:0]  prev;
    logic [PORTS-1:0][PSC_INS-1:0]  mask;
    logic [PORTS-1:0][7:0]          mode;
    logic [PORTS-1:0][PSC_INS-1:0]  flagRise;
    logic [PORTS-1:0][PSC_INS-1:0]  flagFall;
    logic [PSC_DW-1:0]              rdata;
    logic                           intActive;
  } psc_state_s;

  localparam psc_state_s ST_RST = '{outEn: {PORTS{PSC_OUTEN_RST}}, outVal: {PORTS{PSC_OUTVAL_RST}}, default: '0};

  psc_state_s          st_ff;
  psc_state_s          nxt_st;
  logic                inPortWin;
  logic [2:0]          selPort;
  logic [2:0]          selOff;
  logic                thisPort;
  logic                allEn;
  logic                allVal;
  logic [PSC_INS-1:0]  rise;
  logic [PSC_INS-1:0]  fall;
  logic [PSC_INS-1:0]  armed;
  logic [PSC_INS-1:0]  clrRise;
  logic [PSC_INS-1:0]  clrFall;
  logic [PSC_INS-1:0]  riseSeen0;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.rdata = '0;
    inPortWin = busReq.addr < PSC_AW'(PORTS * int'(PSC_PORT_STRIDE));
    selPort   = busReq.addr[5:3];
    selOff    = busReq.addr[2:0];
    // Device-wide and system-wide addresses both hit every port
    allEn     = busReq.wr && (busReq.addr == PSC_ADDR_ALL_OUTEN || busReq.addr == PSC_ADDR_SYS_OUTEN);
    allVal    = busReq.wr && (busReq.addr == PSC_ADDR_ALL_OUTVAL || busReq.addr == PSC_ADDR_SYS_OUTVAL);
    thisPort  = 1'b0;
    rise      = '0;
    fall      = '0;
    armed     = '0;
    clrRise   = '0;
    clrFall   = '0;
    for (int p = 0; p < PORTS; p++)
    begin
      // First stage feeds only the second
      nxt_st.sync1[p] = inPins[p];
      nxt_st.sync2[p] = st_ff.sync1[p];
      nxt_st.prev[p]  = st_ff.sync2[p];
      rise = st_ff.sync2[p] & ~st_ff.prev[p];
      fall = ~st_ff.sync2[p] & st_ff.prev[p];
      for (int i = 0; i < PSC_INS; i++)
      begin
        armed[i] = st_ff.mode[p][PSC_MODE_EN] & (st_ff.mask[p][i] | st_ff.mode[p][PSC_MODE_GRP0 + i / PSC_GRP]);
      end
      thisPort = inPortWin && selPort == 3'(p);
      if ((busReq.wr && thisPort && selOff == PSC_OFF_OUTEN) || allEn)
      begin
        nxt_st.outEn[p] = busReq.wdata[PSC_OUTS-1:0];
      end
      if ((busReq.wr && thisPort && selOff == PSC_OFF_OUTVAL) || allVal)
      begin
        nxt_st.outVal[p] = busReq.wdata[PSC_OUTS-1:0];
      end
      if (busReq.wr && thisPort && selOff == PSC_OFF_INTMASK)
      begin
        nxt_st.mask[p] = busReq.wdata[PSC_INS-1:0];
      end
      if (busReq.wr && thisPort && selOff == PSC_OFF_INTMODE)
      begin
        nxt_st.mode[p] = busReq.wdata[7:0];
      end
      if (busReq.wr && thisPort && selOff == PSC_OFF_INTFLAG)
      begin
        clrRise = busReq.wdata[PSC_INS-1:0];
        clrFall = busReq.wdata[PSC_FLAG_FALL +: PSC_INS];
      end
      else
      begin
        clrRise = '0;
        clrFall = '0;
      end
      // A new edge beats a clear in the same cycle
      nxt_st.flagRise[p] = (st_ff.flagRise[p] & ~clrRise)
                         | (rise & armed & {PSC_INS{st_ff.mode[p][PSC_MODE_RISE]}});
      nxt_st.flagFall[p] = (st_ff.flagFall[p] & ~clrFall)
                         | (fall & armed & {PSC_INS{st_ff.mode[p][PSC_MODE_FALL]}});
      if (busReq.rd && thisPort)
      begin
        case (selOff)
          PSC_OFF_OUTEN:   nxt_st.rdata = PSC_DW'(st_ff.outEn[p]);
          PSC_OFF_OUTVAL:  nxt_st.rdata = PSC_DW'(st_ff.outVal[p]);
          PSC_OFF_INSTAT:  nxt_st.rdata = PSC_DW'(st_ff.sync2[p]);
          PSC_OFF_INTMASK: nxt_st.rdata = PSC_DW'(st_ff.mask[p]);
          PSC_OFF_INTMODE: nxt_st.rdata = PSC_DW'(st_ff.mode[p]);
          PSC_OFF_INTFLAG: nxt_st.rdata = {2'h0, st_ff.flagFall[p], 2'h0, st_ff.flagRise[p]};
          default:         nxt_st.rdata = '0;
        endcase
      end
    end
    // Line held low for as long as any flag stands
    nxt_st.intActive = |{nxt_st.flagRise, nxt_st.flagFall};
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      st_ff <= ST_RST;
    else
      st_ff <= nxt_st;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  for (genvar p = 0; p < PORTS; p++)
  begin : g_out
    assign outPins[p].value = st_ff.outVal[p];
    assign outPins[p].oeN   = ~st_ff.outEn[p];
  end

  // Never drives high, so several devices can share the line
  assign hostIntOut = 1'b0;
  assign hostIntOeN = ~st_ff.intActive;
  assign rdata      = st_ff.rdata;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Masked rising edges of port 0, any bit the bench picks
  assign riseSeen0 = st_ff.sync2[0] & ~st_ff.prev[0] & st_ff.mask[0];

  a_outen_reset: assert property (!$past(reset_n) |-> (outPins[0].oeN == 4'hF))
    else $error("outputs not disabled after reset");
  a_outval_reset: assert property (!$past(reset_n) |-> (outPins[0].value == PSC_OUTVAL_RST))
    else $error("output levels wrong after reset");
  a_port_write: assert property ((busReq.wr && busReq.addr == 8'h01) |=> (outPins[0].value == $past(busReq.wdata[3:0])))
    else $error("port value write not applied");
  a_all_write: assert property ((busReq.wr && busReq.addr == PSC_ADDR_SYS_OUTEN)
                                |=> (outPins[PORTS-1].oeN == ~$past(busReq.wdata[3:0])))
    else $error("system enable write not applied");
  a_instat_read: assert property ((busReq.rd && busReq.addr == 8'h02) |=> (rdata[5:0] == $past(st_ff.sync2[0])))
    else $error("input status read wrong");
  a_sync_depth: assert property ($past(reset_n) && $past(reset_n, 2) |-> (st_ff.sync2[0] == $past(inPins[0], 2)))
    else $error("input not two stages deep");
  a_rise_flag: assert property ((st_ff.mode[0][PSC_MODE_EN] && st_ff.mode[0][PSC_MODE_RISE] && |riseSeen0)
                                |=> ((st_ff.flagRise[0] & $past(riseSeen0)) == $past(riseSeen0)))
    else $error("rising edge flag missed");
  a_group_or: assert property ((!st_ff.sync2[0][1] && st_ff.prev[0][1] && st_ff.mode[0][PSC_MODE_EN]
                                && st_ff.mode[0][PSC_MODE_FALL] && st_ff.mode[0][PSC_MODE_GRP0])
                               |=> (st_ff.flagFall[0][1] && !hostIntOeN))
    else $error("group source edge missed");
  a_flag_sticky: assert property ((|st_ff.flagFall[0] && !(busReq.wr && busReq.addr == 8'h05))
                                  |=> (((st_ff.flagFall[0] & $past(st_ff.flagFall[0])) == $past(st_ff.flagFall[0]))
                                       && !hostIntOeN))
    else $error("flag dropped without clear");
  a_irq_level: assert property ((hostIntOeN == ~|{st_ff.flagRise, st_ff.flagFall}) && !hostIntOut)
    else $error("interrupt line disagrees with flags");

endmodule

// File: tb/psc_far_model.sv
`timescale 1ns/1ns
module psc_far_model
  import psc_pkg::*;
#(
  parameter int PORTS = PSC_PORTS
)(
  // Module side levels
  input  wire logic [PORTS-1:0][PSC_INS-1:0] pinReq,
  output logic      [PORTS-1:0][PSC_INS-1:0] inPins,
  // Shared interrupt line
  input  wire logic                          hostIntOut,
  input  wire logic                          hostIntOeN,
  input  wire logic                          otherOeN,
  output logic                               intLineN
);
  assign inPins = pinReq;
  // Pull-up; any device pulling low wins
  assign intLineN = !((!hostIntOeN && !hostIntOut) || !otherOeN);
endmodule

// File: tb/psc_sideband_tb_top.sv
`timescale 1ns/1ns
module psc_sideband_tb_top;
  import psc_pkg::*;
  logic                  clk;
  logic                  reset_n;
  psc_bus_s              busReq;
  logic [PSC_DW-1:0]     rdata;
  logic [1:0][PSC_INS-1:0] pinReq;
  logic [1:0][PSC_INS-1:0] inPins;
  psc_out_s [1:0]        outPins;
  logic                  hostIntOut;
  logic                  hostIntOeN;
  logic                  otherOeN;
  logic                  intLineN;
  int                    err_total;
  int                    num_checks;
  int                    b;
  logic [15:0]           rv;
  logic [15:0]           d;
  logic [15:0]           e;

  psc_sideband #(.PORTS(2)) dut (.clk(clk), .reset_n(reset_n), .busReq(busReq), .rdata(rdata),
    .inPins(inPins), .outPins(outPins), .hostIntOut(hostIntOut), .hostIntOeN(hostIntOeN));
  psc_far_model #(.PORTS(2)) far (.pinReq(pinReq), .inPins(inPins), .hostIntOut(hostIntOut),
    .hostIntOeN(hostIntOeN), .otherOeN(otherOeN), .intLineN(intLineN));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  function automatic logic [7:0] adr(input int p, input logic [2:0] off);
    return 8'(p) * PSC_PORT_STRIDE + {5'h00, off};
  endfunction

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chkLine(input logic got, input logic exp, input string what);
    chk16({15'h0000, got}, {15'h0000, exp}, what);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] dt);
    @(posedge clk);
    busReq <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 q = rdata;
  endtask

  // Toggle one pin, follow the synchroniser, then read and clear
  task automatic edgeRun(input int p, input int bit_i, input logic lvl, input logic [15:0] fl);
    @(posedge clk);
    pinReq[p][bit_i] <= lvl;
    repeat (2) @(posedge clk);
    #1 chkLine(hostIntOeN, 1'b1, "int early");
    @(posedge clk);
    #1 chkLine(hostIntOeN, fl == 16'h0000, "int edge");
    chkLine(intLineN, fl == 16'h0000, "line");
    chkLine(hostIntOut, 1'b0, "int data");
    rd(adr(p, PSC_OFF_INTFLAG), rv);
    chk16(rv, fl, "flags");
    repeat (6) @(posedge clk);
    #1 chkLine(hostIntOeN, fl == 16'h0000, "int held");
    wr(adr(p, PSC_OFF_INTFLAG), fl);
    chkLine(hostIntOeN, 1'b1, "int cleared");
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog well past the expected run length
  initial
  begin
    #(40 * 20000);
    err_total++;
    finish_test();
  end

  initial
  begin
    busReq = '0;
    reset_n = 1'b0;
    pinReq = '0;
    otherOeN = 1'b1;
    err_total = 0;
    num_checks = 0;
    void'($urandom(32'h63E6));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk16(16'(outPins[1]), 16'h005F, "out reset");
    rd(adr(0, PSC_OFF_OUTEN), rv);
    chk16(rv, 16'h0000, "outen reset");
    rd(adr(0, PSC_OFF_OUTVAL), rv);
    chk16(rv, 16'h0005, "outval reset");
    @(posedge clk);
    #1 chk16(rdata, 16'h0000, "read data one cycle");
    d = 16'($urandom_range(0, 15));
    wr(adr(1, PSC_OFF_OUTVAL), d);
    wr(adr(1, PSC_OFF_OUTEN), 16'h000F);
    chk16(16'(outPins[1]), {8'h00, d[3:0], 4'h0}, "port write");
    chk16(16'(outPins[0]), 16'h005F, "other port");
    wr(adr(0, PSC_OFF_OUTVAL), ~d);
    chk16(16'(outPins[0]), {8'h00, ~d[3:0], 4'hF}, "port zero write");
    chk16(16'(outPins[1]), {8'h00, d[3:0], 4'h0}, "port one kept");
    for (int k = 0; k < 2; k++)
    begin
      d = 16'($urandom_range(0, 15));
      e = 16'($urandom_range(0, 15));
      wr(k == 0 ? PSC_ADDR_ALL_OUTVAL : PSC_ADDR_SYS_OUTVAL, d);
      wr(k == 0 ? PSC_ADDR_SYS_OUTEN : PSC_ADDR_ALL_OUTEN, e);
      for (int p = 0; p < 2; p++)
        chk16(16'(outPins[p]), {8'h00, d[3:0], ~e[3:0]}, "broadcast");
    end
    @(posedge clk);
    pinReq <= 12'($urandom());
    repeat (3) @(posedge clk);
    for (int p = 0; p < 2; p++)
    begin
      rd(adr(p, PSC_OFF_INSTAT), rv);
      chk16(rv, {10'h000, pinReq[p]}, "status");
    end
    @(posedge clk);
    pinReq <= '0;
    repeat (4) @(posedge clk);
    b = $urandom_range(0, 5);
    wr(adr(0, PSC_OFF_INTMASK), 16'(1) << b);
    wr(adr(0, PSC_OFF_INTMODE), 16'h0081);
    edgeRun(0, b, 1'b1, 16'(1) << b);
    wr(adr(0, PSC_OFF_INTMODE), 16'h0082);
    edgeRun(0, b, 1'b0, 16'(1) << (b + PSC_FLAG_FALL));
    wr(adr(0, PSC_OFF_INTMODE), 16'h0083);
    edgeRun(0, b, 1'b1, 16'(1) << b);
    edgeRun(0, b, 1'b0, 16'(1) << (b + PSC_FLAG_FALL));
    // Raise pin 1 while disabled, then catch its fall through the group
    wr(adr(0, PSC_OFF_INTMODE), 16'h0006);
    @(posedge clk);
    pinReq[0][1] <= 1'b1;
    repeat (4) @(posedge clk);
    wr(adr(0, PSC_OFF_INTMODE), 16'h0086);
    edgeRun(0, 1, 1'b0, 16'h0200);
    b = $urandom_range(0, 5);
    wr(adr(1, PSC_OFF_INTMODE), b < 3 ? 16'h0085 : 16'h0089);
    edgeRun(1, b, 1'b1, 16'(1) << b);
    wr(adr(1, PSC_OFF_INTMODE), 16'h000E);
    edgeRun(1, b, 1'b0, 16'h0000);
    @(posedge clk);
    otherOeN <= 1'b0;
    #1 chkLine(intLineN, 1'b0, "shared line");
    chkLine(hostIntOeN, 1'b1, "own pin off");
    rd(8'h16, rv);
    chk16(rv, 16'h0000, "port beyond");
    rd(8'h7F, rv);
    chk16(rv, 16'h0000, "unmapped");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1 chkLine(hostIntOeN, 1'b1, "int after reset");
    for (int p = 0; p < 2; p++)
      chk16(16'(outPins[p]), 16'h005F, "out mid reset");
    finish_test();
  end
endmodule
